// file: hw/fnsc_pkg.sv
// Package: register map, field layouts, reset values and counts of the
// synthesizer control block. Assumes a 16-bit register port, one clock.
// Function
// - Bypass bit high skips the reference divider, giving ratio one.
// - Divider enabled, three-bit code 010 to 111 selects ratio two to seven.
// - Mode pin low uses bank one, mode pin high uses bank two.
// - Loop locks oscillator to effective divide times reference over R.
// - Integer word is integer part; fractional word is fraction times 16777216.
// - Fractional word: upper field sixteen MSBs, lower field eight LSBs.
// - Pump code 31 gives 120uA; low-range bit cuts it to 30uA.
// - Enabled bandwidth correction replaces programmed pump code; off after reset.
// - Active-filter bit enables op-amp; cleared leaves loop-filter pin high impedance.
// - Keep-alive bit runs oscillator while enable low; otherwise oscillator stops.
// - Config word four holds 4-bit coarse load, default 0100, and fine bit.
// - Config word two holds a four-bit bias code per mixer, default 0100.
// - Half duplex enables only the bank's mixer; full duplex enables both.
// - Enable rising edge starts band search of seven 214-tick steps, 1498 ticks; 0 or 127 fails.
// - Hard reset returns every configuration field and state to defaults.
package fnsc_pkg;
  // Register addresses
  localparam logic [3:0] ADDR_CONFIG_WORD_ONE   = 4'h0;
  localparam logic [3:0] ADDR_CONFIG_WORD_TWO   = 4'h1;
  localparam logic [3:0] ADDR_CONFIG_WORD_FOUR   = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'hb;
  localparam int BANK_BASE   = 3;
  localparam int BANK_STRIDE = 4;
  localparam int OFF_INT     = 0;
  localparam int OFF_FUP     = 1;
  localparam int OFF_FLO     = 2;
  localparam int OFF_PUMP    = 3;
  // Reset values
  localparam logic [15:0] CONFIG_WORD_ONE_RESET = 16'h5026;
  localparam logic [15:0] CONFIG_WORD_TWO_RESET = 16'h0044;
  localparam logic [15:0] CONFIG_WORD_FOUR_RESET = 16'h0004;
  localparam logic [9:0]  INT_RESET  = 10'h05c;
  localparam logic [4:0]  PUMP_RESET = 5'h1f;
  // Band search timing in phase-detector ticks
  localparam int BAND_BITS    = 7;
  localparam int SEARCH_TICKS = 1500;
  localparam logic [7:0] STEP_TICKS = 8'(SEARCH_TICKS / BAND_BITS);
  localparam logic [6:0] BAND_FAIL_HI = 7'h7f;
  localparam logic [6:0] BAND_FAIL_LO = 7'h00;
  localparam logic [6:0] BAND_START   = 7'h40;
  localparam logic [2:0] MIN_RATIO    = 3'h2;

  typedef struct packed {
    logic [2:0] refRatio;
    logic       refDivBypass;
    logic [3:0] rsv;
    logic       autoBwCal;
    logic [1:0] bandSearchFactor;
    logic       pumpLowRange;
    logic       oscKeepAlive;
    logic       detectorPolarity;
    logic       activeFilterOn;
    logic       bothMixersOn;
  } fnsc_config_word_one_s;

  typedef struct packed {
    logic [7:0] rsv;
    logic [3:0] mixerTwoBias;
    logic [3:0] mixerOneBias;
  } fnsc_config_word_two_s;

  typedef struct packed {
    logic [10:0] rsv;
    logic        oscLoadFine;
    logic [3:0]  oscLoadCoarse;
  } fnsc_config_word_four_s;

  typedef struct packed {
    logic       busy;
    logic       fail;
    logic       done;
    logic       bankTwo;
    logic       mixOne;
    logic       mixTwo;
    logic [2:0] rsv;
    logic [6:0] result;
  } fnsc_status_s;

  typedef struct packed {
    logic [9:0]  intWord;
    logic [15:0] fracUpper;
    logic [7:0]  fracLower;
    logic [4:0]  pumpCode;
  } fnsc_bank_s;

  typedef enum logic [1:0] {
    SRCH_IDLE = 2'b00,
    SRCH_RUN  = 2'b01,
    SRCH_DONE = 2'b10
  } fnsc_srch_e;

  function automatic logic [3:0] bankAddr(input int b, input int off);
    return 4'(BANK_BASE + b * BANK_STRIDE + off);
  endfunction
endpackage

// file: hw/fnsc_ref_div.sv
// Reference divider: one phase-detector tick every R reference cycles.
// Assumes ratio and bypass come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fnsc_ref_div (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Setting
  input  wire logic       bypass,
  input  wire logic [2:0] ratio,
  // Tick out
  output var  logic       pdTick
);
  logic [2:0] cnt;
  logic [2:0] lastCount;

  // Codes below two are not defined, so they run as divide by two
  always_comb
  begin
    if (bypass)
      lastCount = 3'h0;
    else if (ratio < fnsc_pkg::MIN_RATIO)
      lastCount = fnsc_pkg::MIN_RATIO - 3'h1;
    else
      lastCount = ratio - 3'h1;
  end

  // Counter wraps on the last count so a ratio change takes effect at once
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt    <= 3'h0;
      pdTick <= 1'b0;
    end
    else
    begin
      pdTick <= (cnt >= lastCount);
      cnt    <= (cnt >= lastCount) ? 3'h0 : cnt + 3'h1;
    end
  end

  AST_BYPASS_EVERY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bypass && $past(bypass) && $past(bypass, 2) && $past(rst_n) |-> pdTick)
    else $error("bypassed divider missed a tick");
  AST_RATIO_GAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pdTick && !bypass && ratio >= 3'h3 && $stable(ratio) |=> !pdTick ##1 !pdTick)
    else $error("divided tick came too early");
endmodule
`default_nettype wire

// file: hw/fnsc_frac_acc.sv
// Fractional sequence generator: first-order accumulator on the 24-bit word.
// Assumes tick is a one-cycle pulse from the reference divider.
`timescale 1ns/1ps
`default_nettype none
module fnsc_frac_acc (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Inputs
  input  wire logic        tick,
  input  wire logic [9:0]  intWord,
  input  wire logic [23:0] fracWord,
  // Divider control
  output var  logic [10:0] nCount,
  output var  logic        highModulus
);
  logic [23:0] acc;
  logic [24:0] sum;

  assign sum = {1'b0, acc} + {1'b0, fracWord};

  // Overflow holds the higher modulus for exactly one tick period, R reference cycles
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      acc         <= 24'h000000;
      highModulus <= 1'b0;
      nCount      <= 11'h000;
    end
    else if (tick)
    begin
      acc         <= sum[23:0];
      highModulus <= sum[24];
      nCount      <= {1'b0, intWord} + {10'h000, sum[24]};
    end
  end

  AST_NCOUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick |=> nCount == {1'b0, $past(intWord)} + {10'h000, highModulus})
    else $error("divide count not integer plus carry");
endmodule
`default_nettype wire

// file: hw/fnsc_synth_ctrl.sv
// Top of the synthesizer control block: register file, banks, mode routing,
// band search and pump selection. Assumes pins and analog flags are async.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fnsc_synth_ctrl (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output var  logic [15:0] regRdata,
  // Pins
  input  wire logic        chipEnablePin,
  input  wire logic        modePin,
  // Analog flags
  input  wire logic        vcoFast,
  input  wire logic [4:0]  measuredPumpCode,
  // Divider path
  output var  logic        pdTick,
  output var  logic [10:0] nCount,
  output var  logic        highModulus,
  output var  logic [23:0] fracWord,
  // Pump and filter
  output var  logic [4:0]  pumpCurrentCode,
  output var  logic        pumpLowRange,
  output var  logic        opAmpEnable,
  output var  logic        loopFilterHiZ,
  output var  logic        detectorPolarity,
  output var  logic [1:0]  bandSearchFactor,
  // Oscillator
  output var  logic        oscRun,
  output var  logic        analogEnable,
  output var  logic [3:0]  oscLoadCoarse,
  output var  logic        oscLoadFine,
  // Mixers
  output var  logic [3:0]  mixerOneBias,
  output var  logic [3:0]  mixerTwoBias,
  output var  logic        mixerOneEn,
  output var  logic        mixerTwoEn,
  output var  logic        bankTwoSel,
  // Band search
  output var  logic        bandSearchBusy,
  output var  logic        bandFail,
  output var  logic [6:0]  bandResult
);
  fnsc_pkg::fnsc_config_word_one_s   config_word_one;
  fnsc_pkg::fnsc_config_word_two_s   config_word_two;
  fnsc_pkg::fnsc_config_word_four_s   config_word_four;
  fnsc_pkg::fnsc_status_s status;
  fnsc_pkg::fnsc_bank_s   bank [2];
  fnsc_pkg::fnsc_bank_s   activeBank;
  fnsc_pkg::fnsc_srch_e   srchState;
  logic [7:0]  syncA;
  logic [7:0]  syncB;
  logic        enS;
  logic        modeS;
  logic        vcoFastS;
  logic [4:0]  measS;
  logic        enPrev;
  logic        enRise;
  logic [6:0]  trial;
  logic [6:0]  decided;
  logic [2:0]  stepBit;
  logic [7:0]  stepCnt;
  logic        srchDone;
  logic [10:0] ticksSeen;

  // Two-stage synchroniser; only syncB feeds logic
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      syncA <= 8'h00;
      syncB <= 8'h00;
    end
    else
    begin
      syncA <= {chipEnablePin, modePin, vcoFast, measuredPumpCode};
      syncB <= syncA;
    end
  end

  assign enS      = syncB[7];
  assign modeS    = syncB[6];
  assign vcoFastS = syncB[5];
  assign measS    = syncB[4:0];

  // Global configuration words
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      config_word_one <= fnsc_pkg::CONFIG_WORD_ONE_RESET;
      config_word_two <= fnsc_pkg::CONFIG_WORD_TWO_RESET;
      config_word_four <= fnsc_pkg::CONFIG_WORD_FOUR_RESET;
    end
    else if (regWr)
    begin
      if (regAddr == fnsc_pkg::ADDR_CONFIG_WORD_ONE)
        config_word_one <= {regWdata[15:12], 4'h0, regWdata[7:0]}; // Reserved bits stay zero
      else if (regAddr == fnsc_pkg::ADDR_CONFIG_WORD_TWO)
        config_word_two <= {8'h00, regWdata[7:0]};
      else if (regAddr == fnsc_pkg::ADDR_CONFIG_WORD_FOUR)
        config_word_four <= {11'h000, regWdata[4:0]};
    end
  end

  // Two full programming banks with identical layout
  for (genvar b = 0; b < 2; b++)
  begin : gBank
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
      begin
        bank[b].intWord   <= fnsc_pkg::INT_RESET;
        bank[b].fracUpper <= 16'h0000;
        bank[b].fracLower <= 8'h00;
        bank[b].pumpCode  <= fnsc_pkg::PUMP_RESET;
      end
      else if (regWr)
      begin
        if (regAddr == fnsc_pkg::bankAddr(b, fnsc_pkg::OFF_INT))
          bank[b].intWord <= regWdata[9:0];
        else if (regAddr == fnsc_pkg::bankAddr(b, fnsc_pkg::OFF_FUP))
          bank[b].fracUpper <= regWdata;
        else if (regAddr == fnsc_pkg::bankAddr(b, fnsc_pkg::OFF_FLO))
          bank[b].fracLower <= regWdata[7:0];
        else if (regAddr == fnsc_pkg::bankAddr(b, fnsc_pkg::OFF_PUMP))
          bank[b].pumpCode <= regWdata[4:0];
      end
    end
  end

  // Mode routing is combinational so a mode change needs no extra cycle
  always_comb
  begin
    bankTwoSel = modeS;
    mixerOneEn = !modeS || config_word_one.bothMixersOn;
    mixerTwoEn = modeS || config_word_one.bothMixersOn;
    activeBank = modeS ? bank[1] : bank[0];
  end

  // Fraction reassembled MSB field first
  assign fracWord = {activeBank.fracUpper, activeBank.fracLower};

  fnsc_ref_div uRefDiv (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bypass  (config_word_one.refDivBypass),
    .ratio   (config_word_one.refRatio),
    .pdTick  (pdTick)
  );

  fnsc_frac_acc uFrac (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .tick        (pdTick),
    .intWord     (activeBank.intWord),
    .fracWord    (fracWord),
    .nCount      (nCount),
    .highModulus (highModulus)
  );

  // Pump code: calibration wins only while correction is enabled
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pumpCurrentCode <= fnsc_pkg::PUMP_RESET;
      pumpLowRange    <= 1'b0;
    end
    else
    begin
      pumpCurrentCode <= config_word_one.autoBwCal ? measS : activeBank.pumpCode;
      pumpLowRange    <= config_word_one.pumpLowRange;
    end
  end

  // Filter, load and bias controls straight from the words; oscillator run and analog enable also follow the enable pin
  always_comb
  begin
    opAmpEnable      = config_word_one.activeFilterOn;
    loopFilterHiZ    = !config_word_one.activeFilterOn;
    detectorPolarity = config_word_one.detectorPolarity;
    bandSearchFactor = config_word_one.bandSearchFactor;
    oscRun           = enS || config_word_one.oscKeepAlive;
    analogEnable     = enS;
    oscLoadCoarse    = config_word_four.oscLoadCoarse;
    oscLoadFine      = config_word_four.oscLoadFine;
    mixerOneBias     = config_word_two.mixerOneBias;
    mixerTwoBias     = config_word_two.mixerTwoBias;
  end

  // Enable edge detect on the synchronised level
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      enPrev <= 1'b0;
    else
      enPrev <= enS;
  end

  assign enRise = enS && !enPrev;

  // Bit decision of the current trial: a fast VCO keeps the trial bit off
  assign decided = vcoFastS ? (trial & ~(7'h01 << stepBit)) : trial;

  // Successive approximation over seven bits, one step per STEP_TICKS
  // ticks; dropping the enable aborts, since the analog side is off
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      srchState  <= fnsc_pkg::SRCH_IDLE;
      trial      <= fnsc_pkg::BAND_START;
      stepBit    <= 3'h6;
      stepCnt    <= 8'h00;
      bandResult <= 7'h00;
      bandFail   <= 1'b0;
    end
    else if (enRise)
    begin
      srchState <= fnsc_pkg::SRCH_RUN;
      trial     <= fnsc_pkg::BAND_START;
      stepBit   <= 3'h6;
      stepCnt   <= 8'h00;
      bandFail  <= 1'b0;
    end
    else
    begin
      case (srchState)
        fnsc_pkg::SRCH_RUN:
        begin
          if (!enS)
            srchState <= fnsc_pkg::SRCH_IDLE;
          else if (pdTick && stepCnt == fnsc_pkg::STEP_TICKS - 8'h01)
          begin
            stepCnt <= 8'h00;
            if (stepBit == 3'h0)
            begin
              bandResult <= decided;
              bandFail   <= (decided == fnsc_pkg::BAND_FAIL_LO) ||
                            (decided == fnsc_pkg::BAND_FAIL_HI);
              srchState  <= fnsc_pkg::SRCH_DONE;
            end
            else
            begin
              trial   <= decided | (7'h01 << (stepBit - 3'h1));
              stepBit <= stepBit - 3'h1;
            end
          end
          else if (pdTick)
            stepCnt <= stepCnt + 8'h01;
        end
        fnsc_pkg::SRCH_DONE:
          srchState <= fnsc_pkg::SRCH_DONE;
        default:
          srchState <= fnsc_pkg::SRCH_IDLE;
      endcase
    end
  end

  assign bandSearchBusy = (srchState == fnsc_pkg::SRCH_RUN);
  assign srchDone       = (srchState == fnsc_pkg::SRCH_DONE);

  // Status word shows the block's live state
  always_comb
  begin
    status         = '0;
    status.busy    = bandSearchBusy;
    status.fail    = bandFail;
    status.done    = srchDone;
    status.bankTwo = bankTwoSel;
    status.mixOne  = mixerOneEn;
    status.mixTwo  = mixerTwoEn;
    status.result  = bandResult;
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      regRdata <= 16'h0000;
    else
    begin
      regRdata <= 16'h0000;
      if (regRd)
      begin
        if (regAddr == fnsc_pkg::ADDR_CONFIG_WORD_ONE)
          regRdata <= config_word_one;
        else if (regAddr == fnsc_pkg::ADDR_CONFIG_WORD_TWO)
          regRdata <= config_word_two;
        else if (regAddr == fnsc_pkg::ADDR_CONFIG_WORD_FOUR)
          regRdata <= config_word_four;
        else if (regAddr == fnsc_pkg::ADDR_STATUS)
          regRdata <= status;
        else
        begin
          for (int b = 0; b < 2; b++)
          begin
            if (regAddr == fnsc_pkg::bankAddr(b, fnsc_pkg::OFF_INT))
              regRdata <= {6'h00, bank[b].intWord};
            else if (regAddr == fnsc_pkg::bankAddr(b, fnsc_pkg::OFF_FUP))
              regRdata <= bank[b].fracUpper;
            else if (regAddr == fnsc_pkg::bankAddr(b, fnsc_pkg::OFF_FLO))
              regRdata <= {8'h00, bank[b].fracLower};
            else if (regAddr == fnsc_pkg::bankAddr(b, fnsc_pkg::OFF_PUMP))
              regRdata <= {11'h000, bank[b].pumpCode};
          end
        end
      end
    end
  end

  // Helper: ticks spent in one search, read only by an assertion
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || enRise)
      ticksSeen <= 11'h000;
    else if (bandSearchBusy && pdTick)
      ticksSeen <= ticksSeen + 11'h001;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_BANK_FOLLOWS_MODE: assert property (
    bankTwoSel == syncB[6] && fracWord[7:0] == (syncB[6] ? bank[1].fracLower : bank[0].fracLower))
    else $error("active bank does not follow mode");
  AST_HALF_DUPLEX: assert property (
    !config_word_one.bothMixersOn |-> (mixerOneEn != mixerTwoEn) && (mixerTwoEn == bankTwoSel))
    else $error("half duplex enabled wrong mixer");
  AST_FULL_DUPLEX: assert property (
    config_word_one.bothMixersOn |-> mixerOneEn && mixerTwoEn)
    else $error("full duplex left a mixer off");
  AST_FILTER_PIN: assert property (
    opAmpEnable == config_word_one.activeFilterOn && loopFilterHiZ == !opAmpEnable)
    else $error("op-amp and filter pin disagree");
  AST_OSC_STANDBY: assert property (
    !enS |-> oscRun == config_word_one.oscKeepAlive)
    else $error("oscillator standby wrong");
  AST_PUMP_CAL: assert property (
    config_word_one.autoBwCal |=> pumpCurrentCode == $past(measS))
    else $error("calibrated pump code not used");
  AST_PUMP_PROG: assert property (
    !config_word_one.autoBwCal |=> pumpCurrentCode == $past(activeBank.pumpCode) && pumpLowRange == $past(config_word_one.pumpLowRange))
    else $error("programmed pump code not used");
  AST_FRAC_SPLIT: assert property (
    regWr && regAddr == fnsc_pkg::bankAddr(0, fnsc_pkg::OFF_FUP) |=> bank[0].fracUpper == $past(regWdata))
    else $error("upper fraction field not stored");
  AST_LOAD_WRITE: assert property (
    regWr && regAddr == fnsc_pkg::ADDR_CONFIG_WORD_FOUR |=> oscLoadCoarse == $past(regWdata[3:0]))
    else $error("coarse load not stored");
  AST_SEARCH_START: assert property (
    enRise |=> bandSearchBusy && !bandFail ##1 bandSearchBusy)
    else $error("band search did not start");
  AST_SEARCH_LEN: assert property (
    $rose(srchDone) |-> ticksSeen == 11'(fnsc_pkg::STEP_TICKS) * 11'h007)
    else $error("band search length wrong");
  AST_FAIL_CODE: assert property (
    srchDone |-> bandFail == (bandResult == 7'h00 || bandResult == 7'h7f))
    else $error("band failure flag wrong");
  AST_RESET_DEFAULT: assert property (disable iff (1'b0)
    !rst_n |=> config_word_one == fnsc_pkg::CONFIG_WORD_ONE_RESET && config_word_four == fnsc_pkg::CONFIG_WORD_FOUR_RESET && !bandSearchBusy)
    else $error("reset left a non-default value");

  COV_SEARCH_OK: cover property ($rose(srchDone) && !bandFail);
  COV_FULL_DUPLEX: cover property (config_word_one.bothMixersOn && bankTwoSel);
  COV_CARRY: cover property (pdTick ##1 highModulus);
endmodule
`default_nettype wire

// file: tb/fnsc_host_model.sv
// Host model: drives the register port and the enable and mode pins.
// Assumes one clock; every change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module fnsc_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Register port
  output var  logic [3:0]  regAddr,
  output var  logic [15:0] regWdata,
  output var  logic        regWr,
  output var  logic        regRd,
  input  wire logic [15:0] regRdata,
  // Pins
  output var  logic        chipEnablePin,
  output var  logic        modePin
);
  // Idle bus and pins low from time zero
  initial
  begin
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    chipEnablePin = 1'b0;
    modePin = 1'b0;
  end

  // One-cycle write strobe; the slave never stalls
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so take them then
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask

  // Pins change together just after an edge
  task automatic pins(input logic en, input logic mode);
    @(posedge ref_clk);
    chipEnablePin <= en;
    modePin       <= mode;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_fnsc_synth_ctrl.sv
// Testbench of the synthesizer control block: register rows, mode table,
// divider, accumulator, pump, filter, oscillator and band search.
// Assumes the host model owns the register port and pins.
`timescale 1ns/1ps
`default_nettype none
module tb_fnsc_synth_ctrl;
  logic        ref_clk, rst_n, regWr, regRd, chipEnablePin, modePin, vcoFast;
  logic        pdTick, highModulus, pumpLowRange, opAmpEnable, loopFilterHiZ, detectorPolarity;
  logic        oscRun, analogEnable, oscLoadFine, mixerOneEn, mixerTwoEn, bankTwoSel;
  logic        bandSearchBusy, bandFail;
  logic [1:0]  bandSearchFactor;
  logic [3:0]  regAddr, oscLoadCoarse, mixerOneBias, mixerTwoBias;
  logic [4:0]  measuredPumpCode, pumpCurrentCode;
  logic [6:0]  bandResult;
  logic [10:0] nCount;
  logic [15:0] regWdata, regRdata, rv;
  logic [23:0] fracWord;
  int          errors, cmp_count, n, s, h;
  // Row: address, write data, read-back; reserved bits read 0
  localparam logic [35:0] ROWS [10] = '{36'h0ffff_f0ff, 36'h1ffff_00ff, 36'h2ffff_001f,
    36'h3ffff_03ff, 36'h4ffff_ffff, 36'h5ffff_00ff, 36'h6ffff_001f, 36'ha1234_0014,
    36'hcffff_0000, 36'h8a5c3_a5c3};
  localparam logic [15:0] RST [13] = '{16'h5026, 16'h0044, 16'h0004, 16'h005c, 16'h0, 16'h0,
    16'h001f, 16'h005c, 16'h0, 16'h0, 16'h001f, 16'h0800, 16'h0};

  fnsc_synth_ctrl uut (
    .ref_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .chipEnablePin, .modePin,
    .vcoFast, .measuredPumpCode, .pdTick, .nCount, .highModulus, .fracWord, .pumpCurrentCode,
    .pumpLowRange, .opAmpEnable, .loopFilterHiZ, .detectorPolarity, .bandSearchFactor, .oscRun,
    .analogEnable, .oscLoadCoarse, .oscLoadFine, .mixerOneBias, .mixerTwoBias, .mixerOneEn,
    .mixerTwoEn, .bankTwoSel, .bandSearchBusy, .bandFail, .bandResult
  );
  fnsc_host_model host (
    .ref_clk, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .chipEnablePin, .modePin
  );

  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Settle just past the edge so registered outputs have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic rst;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  // Bounded wait on pdTick (sel 0) or busy (sel 1); a hang ends the run
  task automatic wsig(input int sel, input logic want, input int lim, output int k);
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end
    while (((sel ? bandSearchBusy : pdTick) !== want) && k < lim);
    if ((sel ? bandSearchBusy : pdTick) !== want)
    begin
      errors++;
      $display("unexpected wait expired on select %0d", sel);
      end_sim();
    end
  endtask

  initial
  begin
    rst_n = 1'b0;
    vcoFast = 1'b0;
    measuredPumpCode = 5'h05;
    errors = 0;
    cmp_count = 0;
    rst();
    for (int i = 0; i < 13; i++)
    begin
      host.rd(4'(i), rv);
      chk("reset value", rv, RST[i]);
    end
    chk("pump code", pumpCurrentCode, 5'h1f);
    for (int i = 0; i < 10; i++)
    begin
      host.wr(ROWS[i][35:32], ROWS[i][31:16]);
      host.rd(ROWS[i][35:32], rv);
      chk("read back", rv, ROWS[i][15:0]);
    end
    $display("test registers done");
    // Second reset must undo the all-ones writes
    rst();
    host.rd(4'h0, rv);
    chk("config after reset", rv, 16'h5026);
    host.wr(4'h4, 16'h1111);
    host.wr(4'h5, 16'h0022);
    host.wr(4'h8, 16'hcf32);
    host.wr(4'h9, 16'h0084);
    for (int m = 0; m < 4; m++)
    begin
      host.wr(4'h0, 16'h5026 | 16'(m / 2));
      host.pins(1'b0, m[0]);
      cyc(4);
      chk("bank select", bankTwoSel, m[0]);
      chk("mixer one", mixerOneEn, !m[0] || m[1]);
      chk("mixer two", mixerTwoEn, m[0] || m[1]);
      chk("fraction", fracWord, m[0] ? 24'hcf3284 : 24'h111122);
    end
    $display("test mode table done");
    // Every ratio keeps the 40 MHz reference tick well under 52 MHz
    for (int r = 1; r < 8; r++)
    begin
      host.wr(4'h0, r == 1 ? 16'h1026 : {3'(r), 13'h0026});
      wsig(0, 1'b1, 20, n);
      wsig(0, 1'b1, 20, n);
      wsig(0, 1'b1, 20, n);
      chk("tick period", n, r);
    end
    $display("test divider done");
    host.wr(4'h0, 16'h5026);
    host.wr(4'h4, 16'h8000);
    host.wr(4'h5, 16'h0000);
    host.pins(1'b0, 1'b0);
    cyc(4);
    s = 0;
    h = 0;
    for (int i = 0; i < 16; i++)
    begin
      cyc(1);
      h += int'(highModulus);
      s += int'(nCount);
    end
    chk("carries", h, 8);
    chk("count sum", s, 16 * 92 + 8);
    $display("test accumulator done");
    host.wr(4'h0, 16'h50b6);
    cyc(4);
    chk("low range", pumpLowRange, 1'b1);
    chk("calibrated pump", pumpCurrentCode, 5'h05);
    // Passive filter with inverted polarity, oscillator kept alive
    host.wr(4'h0, 16'h5028);
    cyc(2);
    chk("passive", {opAmpEnable, loopFilterHiZ, detectorPolarity}, 3'b010);
    chk("keep alive", {oscRun, analogEnable}, 2'b10);
    host.wr(4'h0, 16'h5026);
    cyc(4);
    chk("active", {opAmpEnable, loopFilterHiZ, detectorPolarity}, 3'b101);
    chk("osc stopped", oscRun, 1'b0);
    chk("pump restored", pumpCurrentCode, 5'h1f);
    chk("osc loads", {oscLoadFine, oscLoadCoarse}, 5'h04);
    chk("bias and factor", {bandSearchFactor, mixerTwoBias, mixerOneBias}, 10'h144);
    $display("test pump filter osc done");
    // Integer word 92 is above 28, so factor 01 stays; divide lies in 15..511
    @(posedge ref_clk);
    vcoFast <= 1'b1;
    host.pins(1'b1, 1'b0);
    wsig(1, 1'b1, 10, n);
    wsig(1, 1'b0, 3000, n);
    chk("search span", n > 1490 && n < 1510, 1'b1);
    chk("low band", {bandFail, bandResult}, 8'h80);
    @(posedge ref_clk);
    vcoFast <= 1'b0;
    host.pins(1'b0, 1'b0);
    cyc(3);
    host.pins(1'b1, 1'b0);
    wsig(1, 1'b1, 10, n);
    wsig(1, 1'b0, 3000, n);
    chk("high band", {bandFail, bandResult}, 8'hff);
    // Fast only through the first decision: bit 6 clears, the rest stay set
    host.pins(1'b0, 1'b0);
    cyc(3);
    @(posedge ref_clk);
    vcoFast <= 1'b1;
    host.pins(1'b1, 1'b0);
    wsig(1, 1'b1, 10, n);
    repeat (300) @(posedge ref_clk);
    vcoFast <= 1'b0;
    wsig(1, 1'b0, 3000, n);
    chk("good band", {bandFail, bandResult}, 8'h3f);
    host.pins(1'b0, 1'b0);
    cyc(3);
    host.pins(1'b1, 1'b0);
    wsig(1, 1'b1, 10, n);
    host.pins(1'b0, 1'b0);
    cyc(5);
    chk("abort", bandSearchBusy, 1'b0);
    host.pins(1'b1, 1'b0);
    wsig(1, 1'b1, 10, n);
    rst();
    cyc(1);
    chk("busy after reset", {bandSearchBusy, bandFail, bandResult}, 9'h000);
    $display("test band search done");
    end_sim();
  end
endmodule
`default_nettype wire
